// >>> spi_core.v
// Serial peripheral interface with AXI4-Lite registers, mode fault logic and data buffer.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "spi_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Fault flag sets only with detection enabled.
// - Disabling detection keeps an existing fault.
// - Master without detection frees select pin.
// - Detection enabled takes the select pin while the block is enabled.
// - Enabled slave always owns select pin.
// - Master without detection ignores select level.
// - Slave detection off only masks fault.
// - Rate field picks divisor 2/8/32/128.
// - Rate field ignored in slave mode.
// - Reset clears the rate field.
// - Serial clock equals base over 2xdivisor.
// - Data write loads transmit register only.
// - Data read returns receive register.
// - Transmit and receive stored separately.
// - Slave select rise or master low faults.
// - Fault clears: status read, data write.
// - A data read clears receiver full; a byte completing in the same cycle wins.
module spi_core (
  input  wire        aclk,          // Bus clock, 40 MHz.
  input  wire        aresetn,       // Synchronous reset, active low.
  input  wire [7:0]  s_axi_awaddr,  // Write address.
  input  wire        s_axi_awvalid, // Write address valid.
  output reg         s_axi_awready, // Write address ready.
  input  wire [31:0] s_axi_wdata,   // Write data.
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes.
  input  wire        s_axi_wvalid,  // Write data valid.
  output reg         s_axi_wready,  // Write data ready.
  output reg  [1:0]  s_axi_bresp,   // Write response.
  output reg         s_axi_bvalid,  // Write response valid.
  input  wire        s_axi_bready,  // Write response ready.
  input  wire [7:0]  s_axi_araddr,  // Read address.
  input  wire        s_axi_arvalid, // Read address valid.
  output reg         s_axi_arready, // Read address ready.
  output reg  [31:0] s_axi_rdata,   // Read data.
  output reg  [1:0]  s_axi_rresp,   // Read response.
  output reg         s_axi_rvalid,  // Read data valid.
  input  wire        s_axi_rready,  // Read data ready.
  input  wire        sck_in,        // Serial clock pin level.
  output reg         sck_out,       // Serial clock drive.
  output reg         sck_oe,        // Serial clock enable (master).
  input  wire        mosi_in,       // Master-out pin level.
  output reg         mosi_out,      // Master-out drive.
  output reg         mosi_oe,       // Master-out enable.
  input  wire        miso_in,       // Master-in pin level.
  output reg         miso_out,      // Master-in drive.
  output reg         miso_oe,       // Master-in enable (selected slave).
  input  wire        select_n_in,   // Slave-select pin level, active low.
  output reg         select_gpio    // High when the select pin is free for port use.
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.
  reg  [7:0] ctrl_r;          // Control register.
  reg  [7:0] stat_r;          // Writable status and control bits.
  reg        rx_full_r;       // Receiver full flag.
  reg        overflow_r;      // Overflow flag.
  reg        fault_r;         // Select fault flag.
  reg        tx_empty_r;      // Transmit register empty.
  reg  [7:0] tx_data_r;       // Transmit data register, no reset value.
  reg  [7:0] rx_data_r;       // Receive data register, no reset value.
  reg  [7:0] shift_r;         // Shift register.
  reg  [3:0] bit_cnt_r;       // Edges left in a transfer.
  reg        busy_r;          // Transfer under way.
  reg        fault_armed_r;   // Status read seen with fault set.
  reg        ovr_armed_r;     // Status read seen with overflow set.
  reg  [2:0] ss_sync_r;       // Select pin synchroniser.
  reg  [2:0] sck_sync_r;      // Serial clock synchroniser.
  reg  [2:0] mosi_sync_r;     // Master-out synchroniser.
  reg  [2:0] miso_sync_r;     // Master-in synchroniser.
  reg        ss_lvl_r;        // Debounced select level.
  reg        sck_lvl_r;       // Debounced serial clock level.
  reg        aw_hold_r;       // Write address taken.
  reg        w_hold_r;        // Write data taken.
  reg  [7:0] aw_addr_r;       // Held write address.
  reg  [7:0] w_data_r;        // Held write byte.
  reg        w_strb_r;        // Held low lane strobe.
  reg        xfer_done;       // One-cycle pulse when a byte completes.
  reg        sck_prev_r;      // Previous serial clock level for slave edges.
  reg  [7:0] rx_shift_r;      // Incoming bits of the current byte.
  reg  [3:0] rx_cnt_r;        // Bits captured so far in this byte.
  reg  [2:0] samp_dly_r;      // Master sample strobes waiting out the pin lag.
  reg        edges_done_r;    // All sixteen clock edges of the byte are out.
  wire       half_tick;       // Half period pulse from the divider.

  wire enable    = ctrl_r[`CTRL_ENABLE];
  wire master    = ctrl_r[`CTRL_MASTER];
  wire cpha      = ctrl_r[`CTRL_CPHA];
  wire cpol      = ctrl_r[`CTRL_CPOL];
  wire fault_en  = stat_r[`STAT_FAULT_EN];
  // A master without detection never looks at the select level.
  wire ss_used   = enable & (~master | fault_en);
  wire slave_sel = enable & ~master & ~ss_lvl_r;

  // Write fires once both address and data are held; the response follows both.
  wire wr_fire   = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire wr_ok     = (aw_addr_r == `CTRL_ADDR) | (aw_addr_r == `STAT_ADDR) |
                   (aw_addr_r == `DATA_ADDR);
  wire rd_fire   = s_axi_arvalid & s_axi_arready;
  wire data_wr   = wr_fire & w_strb_r & (aw_addr_r == `DATA_ADDR);
  wire data_rd   = rd_fire & (s_axi_araddr == `DATA_ADDR);
  wire stat_rd   = rd_fire & (s_axi_araddr == `STAT_ADDR);

  // Only a master counts the divider, so the rate field cannot touch a slave.
  spi_rate_divider u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (busy_r & master & enable),
    .rate_sel  (stat_r[1:0]),
    .half_tick (half_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a select or clock change counts once the second and third stages agree.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ss_sync_r   <= 3'h7;
      sck_sync_r  <= 3'h0;
      mosi_sync_r <= 3'h0;
      miso_sync_r <= 3'h0;
      ss_lvl_r    <= 1'b1;
      sck_lvl_r   <= 1'b0;
    end else begin
      ss_sync_r   <= {ss_sync_r[1:0], select_n_in};
      sck_sync_r  <= {sck_sync_r[1:0], sck_in};
      mosi_sync_r <= {mosi_sync_r[1:0], mosi_in};
      miso_sync_r <= {miso_sync_r[1:0], miso_in};
      if (ss_sync_r[1] == ss_sync_r[2])
        ss_lvl_r <= ss_sync_r[2];
      if (sck_sync_r[1] == sck_sync_r[2])
        sck_lvl_r <= sck_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data may arrive in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 8'h00;
      w_strb_r      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        w_data_r     <= s_axi_wdata[7:0];
        w_strb_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, answered one cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `AXI_OKAY;
      case (s_axi_araddr)
        `CTRL_ADDR: s_axi_rdata <= {24'h000000, ctrl_r};
        `STAT_ADDR: s_axi_rdata <= {24'h000000, rx_full_r, stat_r[6], overflow_r,
                                    fault_r, tx_empty_r, stat_r[2:0]};
        `DATA_ADDR: s_axi_rdata <= {24'h000000, rx_data_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and status bits, flags and their clearing sequences.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r        <= `CTRL_RESET;
      stat_r        <= `STAT_RESET;
      rx_full_r     <= 1'b0;
      overflow_r    <= 1'b0;
      fault_r       <= 1'b0;
      fault_armed_r <= 1'b0;
      ovr_armed_r   <= 1'b0;
    end else begin
      if (wr_fire && w_strb_r && aw_addr_r == `CTRL_ADDR)
        ctrl_r <= w_data_r;
      // Writing the enable bit low touches nothing else, so a set fault survives.
      if (wr_fire && w_strb_r && aw_addr_r == `STAT_ADDR)
        stat_r <= w_data_r & `STAT_RW_MASK;
      if (stat_rd) begin
        fault_armed_r <= fault_r;
        ovr_armed_r   <= overflow_r;
      end
      // Fault clear needs an armed status read and a data write; a new fault wins.
      if (data_wr && fault_armed_r) begin
        fault_r       <= 1'b0;
        fault_armed_r <= 1'b0;
      end
      if (data_rd) begin
        rx_full_r <= 1'b0;
        if (ovr_armed_r) begin
          overflow_r  <= 1'b0;
          ovr_armed_r <= 1'b0;
        end
      end
      // Slave: select rises mid-transfer. Master: select low at any time.
      if (fault_en && enable && ((~master && busy_r && ss_lvl_r) ||
                                 (master && ~ss_lvl_r)))
        fault_r <= 1'b1;
      if (xfer_done) begin
        if (rx_full_r && !data_rd)
          overflow_r <= 1'b1;
        else
          rx_full_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine, one byte MSB first, in master or slave role.
  wire       sck_edge  = enable & ~master & slave_sel & (sck_lvl_r ^ sck_prev_r);
  wire       edge_tick = master ? half_tick : sck_edge;
  // Sample on the first edge of each bit pair when phase is 0, else on the second.
  wire       sample    = bit_cnt_r[0] ^ cpha;
  wire       samp_tick = edge_tick & sample & ~edges_done_r;
  // The master's input pin lags three cycles, so its sample is taken that much later.
  wire       cap       = master ? samp_dly_r[2] : samp_tick;
  wire       byte_in   = edges_done_r & (rx_cnt_r == 4'h8);

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_r     <= 1'b0;
      bit_cnt_r  <= 4'h0;
      tx_empty_r <= 1'b1;
      xfer_done  <= 1'b0;
      sck_prev_r <= 1'b0;
      sck_out    <= 1'b0;
    end else begin
      xfer_done  <= 1'b0;
      sck_prev_r <= sck_lvl_r;
      if (data_wr) begin
        tx_data_r  <= w_data_r;
        tx_empty_r <= 1'b0;
      end
      if (!enable || (~master && ss_lvl_r)) begin
        busy_r  <= 1'b0;
        sck_out <= cpol;
      end else if (!busy_r && !tx_empty_r && !data_wr) begin
        shift_r      <= tx_data_r;
        tx_empty_r   <= 1'b1;
        busy_r       <= 1'b1;
        bit_cnt_r    <= 4'hF;
        rx_cnt_r     <= 4'h0;
        samp_dly_r   <= 3'h0;
        edges_done_r <= 1'b0;
        sck_out      <= cpol;
      end else if (busy_r) begin
        samp_dly_r <= {samp_dly_r[1:0], master & samp_tick};
        if (edge_tick && !edges_done_r) begin
          // Each tick is half a serial clock; 16 ticks move one byte.
          sck_out      <= master ? ~sck_out : sck_out;
          // The first bit stands from the load, so no shift on the first or last change.
          if (!sample && bit_cnt_r != 4'hF && bit_cnt_r != 4'h0)
            shift_r <= {shift_r[6:0], 1'b0};
          bit_cnt_r    <= bit_cnt_r - 4'h1;
          edges_done_r <= (bit_cnt_r == 4'h0);
        end
        if (cap) begin
          rx_shift_r <= {rx_shift_r[6:0], master ? miso_sync_r[2] : mosi_sync_r[2]};
          rx_cnt_r   <= rx_cnt_r + 4'h1;
        end
        if (byte_in) begin
          busy_r    <= 1'b0;
          xfer_done <= 1'b1;
          if (!rx_full_r || data_rd)
            rx_data_r <= rx_shift_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership and drive; all outputs are registered.
  always @(posedge aclk) begin
    if (!aresetn) begin
      select_gpio <= 1'b1;
      sck_oe      <= 1'b0;
      mosi_oe     <= 1'b0;
      miso_oe     <= 1'b0;
      mosi_out    <= 1'b0;
      miso_out    <= 1'b0;
    end else begin
      // Free only when disabled or master without detection.
      select_gpio <= ~ss_used;
      sck_oe      <= enable & master;
      mosi_oe     <= enable & master;
      miso_oe     <= slave_sel;
      mosi_out    <= shift_r[7];
      miso_out    <= shift_r[7];
    end
  end
endmodule // spi_core

// >>> spi_defines.vh
// Register offsets, field positions, reset values and timing counts of the serial interface.
`ifndef SPI_DEFINES_VH
`define SPI_DEFINES_VH
`define CTRL_INDEX        8'h10
`define STAT_INDEX        8'h11
`define DATA_INDEX        8'h12
`define CTRL_ADDR         8'h40
`define STAT_ADDR         8'h44
`define DATA_ADDR         8'h48
`define CTRL_RX_IE        7
`define CTRL_MASTER       5
`define CTRL_CPOL         3
`define CTRL_CPHA         2
`define CTRL_ENABLE       1
`define CTRL_TX_IE        0
`define CTRL_RESET        8'h24
`define STAT_RX_FULL      7
`define STAT_ERR_IE       6
`define STAT_OVERFLOW     5
`define STAT_FAULT        4
`define STAT_FAULT_EN     2
`define STAT_RATE_HI      1
`define STAT_RATE_LO      0
`define STAT_RW_MASK      8'h47
`define STAT_RESET        8'h00
`define DIV_00            8'h02
`define DIV_01            8'h08
`define DIV_10            8'h20
`define DIV_11            8'h80
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2
`endif

// >>> spi_mode_fault_rate_and_data_buffer_properties.sv
// Checker for bus handshakes, select pin ownership and serial clock rate.
`timescale 1ns/1ps
`include "spi_defines.vh"
module spi_mode_fault_rate_and_data_buffer_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        sck_out,
  input wire        sck_oe,
  input wire        select_gpio
);
  reg  [4:0] cfg_r;     // Written enable, master, detect and rate.
  reg  [1:0] settle_r;  // Cycles since a setting changed.
  reg  [7:0] gap_r;     // Cycles since the last clock edge.
  reg        armed_r, stat_rd_r, sck_q, seen_r;
  wire       go  = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
  wire       tgl = sck_out != sck_q;
  wire [7:0] bd  = 8'h02 << {cfg_r[1:0], 1'b0};
  ////////////////////////////////////////
  // Shadow of the settings; registered pins need a few cycles to follow a write.
  always @(posedge aclk) begin
    sck_q <= sck_out;
    if (!aresetn) begin
      cfg_r <= 5'h08;
      settle_r <= 2'h0;
      gap_r <= 8'h00;
      armed_r <= 1'b0;
      stat_rd_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      if (go && s_axi_awaddr == `CTRL_ADDR)
        cfg_r[4:3] <= {s_axi_wdata[`CTRL_ENABLE], s_axi_wdata[`CTRL_MASTER]};
      if (go && s_axi_awaddr == `STAT_ADDR) begin
        cfg_r[2:0] <= s_axi_wdata[2:0];
        armed_r <= armed_r | s_axi_wdata[`STAT_FAULT_EN];
      end
      settle_r <= (go && s_axi_awaddr != `DATA_ADDR) ? 2'h0 : settle_r + {1'b0, settle_r != 2'h3};
      if (s_axi_arvalid && s_axi_arready) stat_rd_r <= s_axi_araddr == `STAT_ADDR;
      gap_r <= tgl ? 8'h01 : gap_r + {7'h00, gap_r != 8'hFF};
      seen_r <= sck_oe & (seen_r | tgl);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  chk_write_answer: assert property (go |-> ##[1:4] s_axi_bvalid)
    else $error("write not answered");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready while busy");
  chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `AXI_SLVERR |-> !s_axi_rdata)
    else $error("refused read returned data");
  chk_select_owner: assert property (settle_r == 2'h3 |->
    select_gpio == (!cfg_r[4] | (cfg_r[3] & !cfg_r[2]))) else $error("select pin owner wrong");
  chk_fault_armed: assert property (s_axi_rvalid && stat_rd_r && !armed_r |->
    !s_axi_rdata[`STAT_FAULT]) else $error("fault set while detection off");
  chk_slave_quiet: assert property (settle_r == 2'h3 && cfg_r[4:3] == 2'h2 |-> !sck_oe)
    else $error("slave drives clock");
  chk_rate_gap: assert property (tgl && seen_r |-> gap_r >= bd)
    else $error("serial clock too fast");
  cover property (go && s_axi_awaddr == `DATA_ADDR);
  cover property (tgl && seen_r && gap_r == 8'h80);
  cover property (s_axi_rvalid && s_axi_rresp == `AXI_SLVERR);
endmodule // spi_mode_fault_rate_and_data_buffer_properties

// >>> spi_peer_model.sv
// Behavioural external slave answering the master on the serial link.
`timescale 1ns/1ps
module spi_peer_model (
  input  wire       sck,
  input  wire       mosi,
  input  wire       sel_n,
  input  wire [7:0] tx_byte,
  output reg        miso,
  output reg  [7:0] rx_byte
);
  reg [7:0] sh_r;  // Outgoing byte.
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  ////////////////////////////////////////
  // Selection loads the answer so its top bit is ready for the first edge.
  always @(negedge sel_n) sh_r = tx_byte;
  // Leading edge drives, top bit first.
  always @(posedge sck) if (!sel_n) begin
    miso <= sh_r[7];
    sh_r <= {sh_r[6:0], 1'b0};
  end
  // Trailing edge samples the master.
  always @(negedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
  // Released line must not keep showing the last bit.
  always @(posedge sel_n) miso <= ~miso;
endmodule // spi_peer_model

// >>> spi_rate_divider.v
// Master serial clock rate divider producing half-bit enable pulses.
`timescale 1ns/1ps
`include "spi_defines.vh"
module spi_rate_divider (
  input  wire       aclk,      // Bus clock, used as the base clock.
  input  wire       aresetn,   // Synchronous reset, active low.
  input  wire       run,       // Count only while a master transfer runs.
  input  wire [1:0] rate_sel,  // Two-bit rate select field.
  output reg        half_tick  // One-cycle pulse per serial clock half period.
);
  reg  [7:0] cnt_r;     // Cycles counted in the current half period.
  reg  [7:0] divisor;   // Selected rate divisor.

  // Map the rate select field to its divisor.
  always @* begin
    case (rate_sel)
      2'b00:   divisor = `DIV_00;
      2'b01:   divisor = `DIV_01;
      2'b10:   divisor = `DIV_10;
      default: divisor = `DIV_11;
    endcase
  end

  // A half period is divisor cycles, so a full serial clock is 2 x divisor base cycles.
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r     <= 8'h00;
      half_tick <= 1'b0;
    end else if (cnt_r == divisor - 8'h01) begin
      cnt_r     <= 8'h00;
      half_tick <= 1'b1;
    end else begin
      cnt_r     <= cnt_r + 8'h01;
      half_tick <= 1'b0;
    end
  end
endmodule // spi_rate_divider

// >>> tb_spi_mode_fault_rate_and_data_buffer.sv
// Testbench for select ownership, mode fault, rate and data buffer.
`timescale 1ns/1ps
`include "spi_defines.vh"
module tb_spi_mode_fault_rate_and_data_buffer;
  reg         aclk = 1'b0, aresetn = 1'b0, sck_q = 1'b0, select_n_in = 1'b1;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, peer_tx = 8'h00, pt, d;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1;  // Answers always taken.
  reg  [31:0] s_axi_wdata = 32'h0, rd;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg  [1:0]  rs;
  integer     n_fail = 0, check_count = 0, cyc = 0, t_first = 0, t_last = 0, n_tgl = 0, i;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, select_gpio, peer_miso;
  wire [7:0]  peer_rx;
  // Undriven clock idles low; undriven data line is pulled high.
  wire        sck_in  = sck_oe ? sck_out : 1'b0;
  wire        mosi_in = mosi_oe ? mosi_out : 1'b1;
  wire        miso_in = miso_oe ? miso_out : peer_miso;
  always #12.5 aclk = ~aclk;
  spi_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in,
    .miso_out, .miso_oe, .select_n_in, .select_gpio);
  spi_peer_model u_peer (.sck(sck_in), .mosi(mosi_in), .sel_n(select_n_in),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));
  ////////////////////////////////////////
  // Log of clock edges, to measure how long one byte takes.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    sck_q <= sck_out;
    if (sck_oe && sck_out !== sck_q) begin
      if (n_tgl == 0) t_first <= cyc;
      t_last <= cyc;
      n_tgl <= n_tgl + 1;
    end
  end
  function integer bd_of(input [1:0] r);
    bd_of = 2 << (2 * r);
  endfunction
  task check(input [33:0] got, input [33:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t ns: saw %h, wanted %h", $time, got, exp);
      end
    end
  endtask
  // Address and data go together; each drops once taken.
  task wr(input [7:0] a, input [7:0] v);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
    end
  endtask
  task wait_rx;
    do rd_reg(`STAT_ADDR);
    while (rd[`STAT_RX_FULL] !== 1'b1);
  endtask
  task stop_test;
    begin
      $display("checks %0d, failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Watchdog; the slowest byte takes about two thousand cycles.
  initial begin
    repeat (60000) @(posedge aclk);
    n_fail = n_fail + 1;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    stop_test;
  end
  initial begin
    void'($urandom(75));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`CTRL_ADDR);
    check(rd, `CTRL_RESET);
    rd_reg(`STAT_ADDR);
    check(rd[1:0], 2'h0);
    rd_reg(8'h4C);
    check({rs, rd}, {`AXI_SLVERR, 32'h0});
    $display("reset test done");
    // Each rate in turn, select held low, detection off; bytes are written fresh.
    for (i = 0; i < 4; i = i + 1) begin
      pt = $urandom;
      d = (i == 0) ? 8'h00 : (i == 3) ? 8'hFF : $urandom;
      peer_tx <= pt;
      n_tgl = 0;
      wr(`STAT_ADDR, i[7:0]);
      wr(`CTRL_ADDR, 8'h26);
      select_n_in <= 1'b0;
      repeat (4) @(posedge aclk);
      wr(`DATA_ADDR, d);
      wait_rx;
      check(rd[`STAT_FAULT], 1'b0);
      rd_reg(`DATA_ADDR);
      check(rd[7:0], pt);
      check(peer_rx, d);
      check(t_last - t_first, 15 * bd_of(i));
      check(n_tgl, 16);
      rd_reg(`STAT_ADDR);
      check(rd[`STAT_RX_FULL], 1'b0);
      select_n_in <= 1'b1;
    end
    wr(`DATA_ADDR, ~pt);
    rd_reg(`DATA_ADDR);
    check(rd[7:0], pt);
    wait_rx;
    rd_reg(`DATA_ADDR);
    $display("rate and data test done");
    wr(`STAT_ADDR, 8'h04);
    repeat (4) @(posedge aclk);
    check(select_gpio, 1'b0);
    select_n_in <= 1'b0;
    repeat (8) @(posedge aclk);
    rd_reg(`STAT_ADDR);
    check(rd[`STAT_FAULT], 1'b1);
    select_n_in <= 1'b1;
    wr(`CTRL_ADDR, 8'h26);
    wr(`STAT_ADDR, 8'h00);
    rd_reg(`STAT_ADDR);
    check(rd[`STAT_FAULT], 1'b1);
    wr(`DATA_ADDR, 8'h5A);
    rd_reg(`STAT_ADDR);
    check(rd[`STAT_FAULT], 1'b0);
    wait_rx;
    rd_reg(`DATA_ADDR);
    select_n_in <= 1'b0;
    repeat (8) @(posedge aclk);
    rd_reg(`STAT_ADDR);
    check(rd[`STAT_FAULT], 1'b0);
    check(select_gpio, 1'b1);
    $display("mode fault test done");
    wr(`CTRL_ADDR, 8'h06);
    wr(`STAT_ADDR, 8'h03);
    repeat (4) @(posedge aclk);
    check(select_gpio, 1'b0);
    check(sck_oe, 1'b0);
    $display("slave test done");
    stop_test;
  end
endmodule // tb_spi_mode_fault_rate_and_data_buffer
bind spi_core spi_mode_fault_rate_and_data_buffer_properties u_chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .sck_out, .sck_oe, .select_gpio);
